// file: rtl/serial_audio_map.svh
`ifndef SERIAL_AUDIO_MAP_SVH
`define SERIAL_AUDIO_MAP_SVH

// Register byte addresses
`define SA_ADDR_W         5
`define SA_IN_CFG_ADDR    5'h00
`define SA_OUT_CFG_ADDR   5'h04
`define SA_PLL_SEL_ADDR   5'h08
`define SA_PLL_RATIO_ADDR 5'h0C
`define SA_TX_WORD_ADDR   5'h10
`define SA_STATUS_ADDR    5'h14
`define SA_RX_WORD_ADDR   5'h18

// Group configuration fields
`define SA_SCALER_LSB     0
`define SA_SCALER_FIELD_W 8
`define SA_MASTER_BIT     8
`define SA_EDGE_POL_BIT   9
`define SA_FRAMING_BIT    10
`define SA_WS_POL_BIT     11
`define SA_FORMAT_LSB     12
`define SA_CLK_SRC_BIT    15
`define SA_PORT_F_BIT     16
`define SA_GROUP_CFG_W    17

// PLL select fields
`define SA_PLL_REF_BIT    0
`define SA_AUD_SRC_BIT    1
`define SA_DOUBLE_BIT     2
`define SA_RX_EN_BIT      3
`define SA_PLL_SEL_W      4

// PLL ratio fields
`define SA_MULT_LSB       0
`define SA_MULT_W         8
`define SA_DIV_LSB        8
`define SA_DIV_W          16

// Reset values and framing counts
`define SA_GROUP_CFG_RST  17'h01001
`define SA_PLL_SEL_RST    4'h0
`define SA_MULT_RST       8'h04
`define SA_DIV_RST        16'h0D58
`define SA_WORD_W         16
`define SA_HALF_FRAME     32
`define SA_SYNC_STAGES    3

`endif

// file: rtl/serial_audio_pkg.sv
package serial_audio_pkg;

	typedef enum logic [2:0] {
		FMT_NONDELAYED = 3'h0,
		FMT_DELAYED    = 3'h1,
		FMT_FRAMELESS  = 3'h6,
		FMT_EIAJ       = 3'h7
	} format_type;

	typedef enum logic [1:0] {
		FRAMING_SYNC = 2'h1,
		FRAMING_WORD = 2'h2
	} framing_type;

endpackage

// file: rtl/bit_clock_divider.sv
`timescale 1ns/1ns
module bit_clock_divider #(
	parameter int SCALER_W = 12
) (
	input  wire logic                core_clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                prescale_lvl_i,
	input  wire logic                both_edges_i,
	input  wire logic [SCALER_W-1:0] scaler_i,
	output logic                     bclk_o
);
	logic                prev_q;
	logic [SCALER_W-1:0] cnt_q;
	logic                tick;
	logic                bypass;
	logic                last;

	assign tick   = both_edges_i ? (prescale_lvl_i ^ prev_q) : (prescale_lvl_i & ~prev_q);
	assign bypass = (scaler_i <= SCALER_W'(1));
	assign last   = (cnt_q == scaler_i - SCALER_W'(1));

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= prescale_lvl_i;
		end
	end

	// Half period is scaler prescale ticks, so duty stays at 50 percent
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
		end else if (bypass) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= last ? '0 : cnt_q + SCALER_W'(1);
		end
	end

	// Scaler of one passes the prescale clock straight through
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			bclk_o <= 1'b0;
		end else if (bypass) begin
			bclk_o <= prescale_lvl_i;
		end else if (tick && last) begin
			bclk_o <= ~bclk_o;
		end
	end

	property p_div_toggle;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!bypass && tick && last && $stable(scaler_i)) |=> (bclk_o != $past(bclk_o));
	endproperty
	a_div_toggle: assert property (p_div_toggle) else $error("divider missed its toggle");

	property p_div_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!bypass && !tick && $stable(scaler_i)) |=> $stable(bclk_o);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divider toggled without a tick");

	property p_div_bypass;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		bypass |=> (bclk_o == $past(prescale_lvl_i));
	endproperty
	a_div_bypass: assert property (p_div_bypass) else $error("bypass did not follow prescale");
endmodule

// file: rtl/serial_audio_port_clocking.sv
`timescale 1ns/1ns
`include "serial_audio_map.svh"
module serial_audio_port_clocking #(
	parameter int SCALER_W = 12
) (
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic [`SA_ADDR_W-1:0]         reg_addr_i,
	input  wire logic [31:0]                   reg_wdata_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	output logic      [31:0]                   reg_rdata_o,
	input  wire logic                          system_clock_i,
	input  wire logic                          pll_clock_i,
	input  wire logic                          receiver_lock_i,
	output logic                               pll_reference_sel_o,
	output logic      [`SA_MULT_W-1:0]         audio_pll_multiplier_o,
	output logic      [`SA_DIV_W-1:0]          audio_pll_divisor_o,
	input  wire logic                          master_clock_pin_i,
	output logic                               master_clock_pin_o,
	output logic                               master_clock_pin_oe_o,
	input  wire logic                          input_bit_clock_i,
	output logic                               input_bit_clock_o,
	output logic                               input_bit_clock_oe_o,
	input  wire logic                          input_framing_i,
	output logic                               input_framing_o,
	output logic                               input_framing_oe_o,
	input  wire logic                          output_bit_clock_i,
	output logic                               output_bit_clock_o,
	output logic                               output_bit_clock_oe_o,
	input  wire logic                          output_framing_i,
	output logic                               output_framing_o,
	output logic                               output_framing_oe_o,
	input  wire logic [2:0]                    serial_in_i,
	output logic      [3:0]                    serial_out_o,
	output logic      [`SA_WORD_W-1:0]         frameless_word_o,
	output logic                               frameless_word_valid_o,
	output serial_audio_pkg::format_type       input_format_o
);
	import serial_audio_pkg::*;

	localparam int SYNC_W = 10;

	function automatic logic edge_tick(input logic pol, input logic rise, input logic fall);
		edge_tick = pol ? fall : rise;
	endfunction

	function automatic logic [SCALER_W-1:0] scaler_of(input logic [`SA_GROUP_CFG_W-1:0] cfg);
		scaler_of = SCALER_W'(cfg[`SA_SCALER_LSB +: `SA_SCALER_FIELD_W]);
	endfunction

	logic [`SA_GROUP_CFG_W-1:0] in_cfg_q;
	logic [`SA_GROUP_CFG_W-1:0] out_cfg_q;
	logic [`SA_PLL_SEL_W-1:0]   pll_sel_q;
	logic [`SA_WORD_W-1:0]      tx_word_q;
	logic [SYNC_W-1:0]          s1_q;
	logic [SYNC_W-1:0]          s2_q;
	logic [SYNC_W-1:0]          s3_q;
	logic [SYNC_W-1:0]          pin_q;
	logic                       aud_lvl;
	logic                       aud_double;
	logic                       pre_b_lvl;
	logic                       div_a;
	logic                       div_b;
	logic                       bclk_a;
	logic                       bclk_b;
	logic                       prev_a_q;
	logic                       prev_b_q;
	logic                       latch_a;
	logic                       send_a;
	logic                       latch_b;
	logic                       send_b;
	logic                       latch_f;
	logic [5:0]                 frm_a_q;
	logic [5:0]                 frm_b_q;
	logic [3:0]                 rx_cnt_q;
	logic [`SA_WORD_W-1:0]      rx_shift_q;
	logic [`SA_WORD_W-1:0]      tx_shift_q;
	logic [2:0]                 port_bits_q;
	logic                       in_master;
	logic                       out_master;
	logic                       frameless;
	logic                       fs_in_active;
	logic                       pin_drive;

	assign in_master  = in_cfg_q[`SA_MASTER_BIT];
	assign out_master = out_cfg_q[`SA_MASTER_BIT];
	assign frameless  = (in_cfg_q[`SA_FORMAT_LSB +: 3] == FMT_FRAMELESS);
	// Receiver drives the pin whatever the clock select says
	assign pin_drive  = out_cfg_q[`SA_CLK_SRC_BIT] | pll_sel_q[`SA_RX_EN_BIT];

	// Configuration changes only through these writes
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			in_cfg_q  <= `SA_GROUP_CFG_RST;
			out_cfg_q <= `SA_GROUP_CFG_RST;
			pll_sel_q <= `SA_PLL_SEL_RST;
			tx_word_q <= '0;
			audio_pll_multiplier_o <= `SA_MULT_RST;
			audio_pll_divisor_o    <= `SA_DIV_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `SA_IN_CFG_ADDR) begin
				in_cfg_q <= {1'b0, 1'b0, reg_wdata_i[`SA_GROUP_CFG_W-3:0]};
			end else if (reg_addr_i == `SA_OUT_CFG_ADDR) begin
				out_cfg_q <= reg_wdata_i[`SA_GROUP_CFG_W-1:0];
			end else if (reg_addr_i == `SA_PLL_SEL_ADDR) begin
				pll_sel_q <= reg_wdata_i[`SA_PLL_SEL_W-1:0];
			end else if (reg_addr_i == `SA_PLL_RATIO_ADDR) begin
				audio_pll_multiplier_o <= reg_wdata_i[`SA_MULT_LSB +: `SA_MULT_W];
				audio_pll_divisor_o    <= reg_wdata_i[`SA_DIV_LSB +: `SA_DIV_W];
			end else if (reg_addr_i == `SA_TX_WORD_ADDR) begin
				tx_word_q <= reg_wdata_i[`SA_WORD_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_addr_i == `SA_IN_CFG_ADDR) begin
			reg_rdata_o <= 32'(in_cfg_q);
		end else if (reg_addr_i == `SA_OUT_CFG_ADDR) begin
			reg_rdata_o <= 32'(out_cfg_q);
		end else if (reg_addr_i == `SA_PLL_SEL_ADDR) begin
			reg_rdata_o <= 32'(pll_sel_q);
		end else if (reg_addr_i == `SA_PLL_RATIO_ADDR) begin
			reg_rdata_o <= {8'h00, audio_pll_divisor_o, audio_pll_multiplier_o};
		end else if (reg_addr_i == `SA_TX_WORD_ADDR) begin
			reg_rdata_o <= 32'(tx_word_q);
		end else if (reg_addr_i == `SA_STATUS_ADDR) begin
			reg_rdata_o <= {21'h0, rx_cnt_q, port_bits_q, pin_q[9], aud_lvl, bclk_b, bclk_a};
		end else if (reg_addr_i == `SA_RX_WORD_ADDR) begin
			reg_rdata_o <= 32'(frameless_word_o);
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

	// Pins: a change counts once stages two and three agree
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= {receiver_lock_i, serial_in_i, output_framing_i, input_framing_i,
				output_bit_clock_i, input_bit_clock_i, master_clock_pin_i, pll_clock_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (pin_q & ~(s2_q ~^ s3_q)) | (s3_q & (s2_q ~^ s3_q));
		end
	end

	// Receiver path runs through the PLL whenever the receiver is enabled, whatever the reference select
	assign aud_lvl = (pll_sel_q[`SA_AUD_SRC_BIT] | pll_sel_q[`SA_RX_EN_BIT]) ? pin_q[0] : system_clock_i;
	assign aud_double = pll_sel_q[`SA_RX_EN_BIT] & pll_sel_q[`SA_DOUBLE_BIT];
	assign pre_b_lvl  = pin_drive ? aud_lvl : pin_q[1];

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pll_reference_sel_o   <= 1'b0;
			master_clock_pin_o    <= 1'b0;
			master_clock_pin_oe_o <= 1'b0;
		end else begin
			pll_reference_sel_o   <= pll_sel_q[`SA_PLL_REF_BIT];
			master_clock_pin_o    <= aud_lvl;
			master_clock_pin_oe_o <= pin_drive;
		end
	end

	// System clock is sampled raw; it stands in for an on-chip source
	bit_clock_divider #(.SCALER_W(SCALER_W)) u_div_a (
		.core_clk_i     (core_clk_i),
		.rst_n_i        (rst_n_i),
		.prescale_lvl_i (aud_lvl),
		.both_edges_i   (aud_double),
		.scaler_i       (scaler_of(in_cfg_q)),
		.bclk_o         (div_a)
	);

	bit_clock_divider #(.SCALER_W(SCALER_W)) u_div_b (
		.core_clk_i     (core_clk_i),
		.rst_n_i        (rst_n_i),
		.prescale_lvl_i (pre_b_lvl),
		.both_edges_i   (aud_double & pin_drive),
		.scaler_i       (scaler_of(out_cfg_q)),
		.bclk_o         (div_b)
	);

	assign bclk_a = in_master ? div_a : pin_q[2];
	assign bclk_b = out_master ? div_b : pin_q[3];

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			prev_a_q <= 1'b0;
			prev_b_q <= 1'b0;
		end else begin
			prev_a_q <= bclk_a;
			prev_b_q <= bclk_b;
		end
	end

	assign latch_a = edge_tick(in_cfg_q[`SA_EDGE_POL_BIT], bclk_a & ~prev_a_q, ~bclk_a & prev_a_q);
	assign send_a  = edge_tick(in_cfg_q[`SA_EDGE_POL_BIT], ~bclk_a & prev_a_q, bclk_a & ~prev_a_q);
	assign latch_b = edge_tick(out_cfg_q[`SA_EDGE_POL_BIT], bclk_b & ~prev_b_q, ~bclk_b & prev_b_q);
	assign send_b  = edge_tick(out_cfg_q[`SA_EDGE_POL_BIT], ~bclk_b & prev_b_q, bclk_b & ~prev_b_q);
	assign latch_f = out_cfg_q[`SA_PORT_F_BIT] ? latch_b : latch_a;

	// Frame position counters advance on the send edge
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			frm_a_q <= '0;
		end else if (send_a) begin
			frm_a_q <= frm_a_q + 6'h01;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			frm_b_q <= '0;
		end else if (send_b) begin
			frm_b_q <= frm_b_q + 6'h01;
		end
	end

	// Word select toggles per half frame; frame sync pulses one bit at frame start, or every 16 bits on the input group in frameless format
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			input_framing_o    <= 1'b0;
			input_framing_oe_o <= 1'b0;
			input_bit_clock_o  <= 1'b0;
			input_bit_clock_oe_o <= 1'b0;
		end else begin
			input_bit_clock_o    <= div_a;
			input_bit_clock_oe_o <= in_master;
			input_framing_oe_o   <= in_master;
			if (in_cfg_q[`SA_FRAMING_BIT]) begin
				input_framing_o <= frm_a_q[5] ^ in_cfg_q[`SA_WS_POL_BIT];
			end else if (frameless) begin
				input_framing_o <= (frm_a_q[3:0] == 4'h0) ^ in_cfg_q[`SA_WS_POL_BIT];
			end else begin
				input_framing_o <= (frm_a_q == 6'h00) ^ in_cfg_q[`SA_WS_POL_BIT];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			output_framing_o      <= 1'b0;
			output_framing_oe_o   <= 1'b0;
			output_bit_clock_o    <= 1'b0;
			output_bit_clock_oe_o <= 1'b0;
		end else begin
			output_bit_clock_o    <= div_b;
			output_bit_clock_oe_o <= out_master;
			output_framing_oe_o   <= out_master;
			if (out_cfg_q[`SA_FRAMING_BIT]) begin
				output_framing_o <= frm_b_q[5] ^ out_cfg_q[`SA_WS_POL_BIT];
			end else begin
				output_framing_o <= (frm_b_q == 6'h00) ^ out_cfg_q[`SA_WS_POL_BIT];
			end
		end
	end

	// Incoming sync counts as active at the configured level
	assign fs_in_active = (pin_q[4] ^ in_cfg_q[`SA_WS_POL_BIT]) & ~in_master & frameless;

	// Frameless receive on port A; other formats leave the word path idle
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_cnt_q   <= '0;
			rx_shift_q <= '0;
		end else if (latch_a && frameless) begin
			rx_shift_q <= {rx_shift_q[`SA_WORD_W-2:0], pin_q[6]};
			rx_cnt_q   <= fs_in_active ? 4'h1 : rx_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			frameless_word_o       <= '0;
			frameless_word_valid_o <= 1'b0;
		end else begin
			frameless_word_valid_o <= latch_a && frameless && !fs_in_active && rx_cnt_q == 4'hF;
			if (latch_a && frameless && !fs_in_active && rx_cnt_q == 4'hF) begin
				frameless_word_o <= {rx_shift_q[`SA_WORD_W-2:0], pin_q[6]};
			end
		end
	end

	// Ports A, E, F last sampled bits; F may follow the output clock
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			port_bits_q <= '0;
		end else begin
			if (latch_a) begin
				port_bits_q[1:0] <= pin_q[7:6];
			end
			if (latch_f) begin
				port_bits_q[2] <= pin_q[8];
			end
		end
	end

	// One shared word leaves on all four outputs, MSB first
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tx_shift_q   <= '0;
			serial_out_o <= 4'h0;
		end else if (send_b) begin
			if (frm_b_q[3:0] == 4'h0) begin
				tx_shift_q <= {tx_word_q[`SA_WORD_W-2:0], 1'b0};
				serial_out_o <= {4{tx_word_q[`SA_WORD_W-1]}};
			end else begin
				tx_shift_q <= {tx_shift_q[`SA_WORD_W-2:0], 1'b0};
				serial_out_o <= {4{tx_shift_q[`SA_WORD_W-1]}};
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			input_format_o <= FMT_DELAYED;
		end else begin
			input_format_o <= format_type'(in_cfg_q[`SA_FORMAT_LSB +: 3]);
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_last_bit;
		latch_a && frameless && !fs_in_active && rx_cnt_q == 4'hF;
	endsequence
	sequence s_word_out;
		frameless_word_valid_o ##1 !frameless_word_valid_o;
	endsequence

	property p_word_event;
		s_last_bit |=> s_word_out;
	endproperty
	a_word_event: assert property (p_word_event) else $error("frameless word event missing");

	property p_no_spurious_word;
		!(latch_a && frameless && rx_cnt_q == 4'hF) |=> !frameless_word_valid_o;
	endproperty
	a_no_spurious_word: assert property (p_no_spurious_word) else $error("word event without 16 bits");

	property p_resync;
		(latch_a && fs_in_active) |=> (rx_cnt_q == 4'h1);
	endproperty
	a_resync: assert property (p_resync) else $error("slave sync did not realign");

	property p_latch_only;
		!(latch_a && frameless) |=> $stable(rx_shift_q);
	endproperty
	a_latch_only: assert property (p_latch_only) else $error("sample off the latch edge");

	property p_cfg_hold;
		!reg_wr_i |=> ($stable(in_cfg_q) && $stable(out_cfg_q) && $stable(pll_sel_q));
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without a write");

	property p_pin_drive;
		pin_drive |=> master_clock_pin_oe_o ##0 (master_clock_pin_o == $past(aud_lvl));
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("master clock pin not driven");

	property p_pin_input;
		!pin_drive |=> !master_clock_pin_oe_o;
	endproperty
	a_pin_input: assert property (p_pin_input) else $error("master clock pin driven as input");

	property p_master_oe;
		(in_master && !out_master) |=> (input_bit_clock_oe_o && !output_bit_clock_oe_o);
	endproperty
	a_master_oe: assert property (p_master_oe) else $error("group master select crossed");

	property p_scaler_width;
		(reg_wr_i && reg_addr_i == `SA_IN_CFG_ADDR) |=>
			(in_cfg_q[`SA_SCALER_LSB +: `SA_SCALER_FIELD_W] == $past(reg_wdata_i[`SA_SCALER_LSB +: `SA_SCALER_FIELD_W]));
	endproperty
	a_scaler_width: assert property (p_scaler_width) else $error("input scaler field not taken");
endmodule

// file: tb/audio_source_model.sv
`timescale 1ns/1ns
module audio_source_model (
	input  wire logic core_clk_i,
	input  wire logic invert_i,
	output logic      bit_clock_o,
	output logic      framing_o,
	output logic      data_o
);
	logic raw_q = 1'b0;
	logic sync_q = 1'b0;
	logic bit_q = 1'b1;

	// Clock stands still between frames
	assign bit_clock_o = raw_q ^ invert_i;
	assign framing_o = sync_q;
	assign data_o = bit_q;

	// Line turns over mid-high, so a wrong latch edge sees the inverse bit
	task automatic send(input logic [15:0] word, input int nbits, input logic sync);
		for (int i = nbits - 1; i >= 0; i--) begin
			@(posedge core_clk_i);
			bit_q <= word[i];
			sync_q <= sync && (i == nbits - 1);
			repeat (3) @(posedge core_clk_i);
			raw_q <= 1'b1;
			repeat (3) @(posedge core_clk_i);
			bit_q <= ~word[i];
			sync_q <= 1'b0;
			repeat (3) @(posedge core_clk_i);
			raw_q <= 1'b0;
			repeat (2) @(posedge core_clk_i);
		end
	endtask
endmodule

// file: tb/serial_audio_port_clocking_bench.sv
`timescale 1ns/1ns
`include "serial_audio_map.svh"
module serial_audio_port_clocking_bench;
	import serial_audio_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [4:0]  addr = '0;
	logic [31:0] wdata = '0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        lock = 1'b0;
	logic        inv = 1'b0;
	logic        probe_sel = 1'b0;
	logic        probe_q = 1'b0;
	logic [3:0]  div_q = '0;
	logic [15:0] last_word = '0;
	int          n_words = 0;
	int          errors = 0;
	int          checks = 0;
	wire  [31:0] rdata;
	wire  [7:0]  mult;
	wire  [15:0] divisor;
	wire  [15:0] fl_word;
	wire  [3:0]  sout;
	wire         fl_valid, pll_ref, mck_o, mck_oe, ib_o, ib_oe, if_o, if_oe, ob_o, ob_oe, of_o, of_oe;
	wire         src_bclk, src_frame, src_data;
	format_type  fmt;
	// Two-way pins resolved from the drivers' enables
	// Released master clock pin carries an outside clock of period 8
	wire         mck = mck_oe ? mck_o : div_q[2];
	wire         ib = ib_oe ? ib_o : src_bclk;
	wire         ifr = if_oe ? if_o : src_frame;
	wire         ob = ob_oe ? ob_o : 1'b0;
	wire         ofr = of_oe ? of_o : 1'b0;
	wire         probe = probe_sel ? ob_o : ib_o;

	serial_audio_port_clocking #(.SCALER_W(12)) u_dut (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .system_clock_i(div_q[2]),
		.pll_clock_i(div_q[3]), .receiver_lock_i(lock), .pll_reference_sel_o(pll_ref),
		.audio_pll_multiplier_o(mult), .audio_pll_divisor_o(divisor), .master_clock_pin_i(mck),
		.master_clock_pin_o(mck_o), .master_clock_pin_oe_o(mck_oe), .input_bit_clock_i(ib),
		.input_bit_clock_o(ib_o), .input_bit_clock_oe_o(ib_oe), .input_framing_i(ifr),
		.input_framing_o(if_o), .input_framing_oe_o(if_oe), .output_bit_clock_i(ob),
		.output_bit_clock_o(ob_o), .output_bit_clock_oe_o(ob_oe), .output_framing_i(ofr),
		.output_framing_o(of_o), .output_framing_oe_o(of_oe), .serial_in_i({3{src_data}}),
		.serial_out_o(sout), .frameless_word_o(fl_word), .frameless_word_valid_o(fl_valid),
		.input_format_o(fmt));

	audio_source_model u_src (.core_clk_i(core_clk_i), .invert_i(inv), .bit_clock_o(src_bclk),
		.framing_o(src_frame), .data_o(src_data));

	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	// Prescale sources: system level period 8, PLL level period 16
	always @(posedge core_clk_i) begin
		probe_q <= probe;
		div_q <= div_q + 4'h1;
		if (fl_valid === 1'b1) begin
			n_words++;
			last_word <= fl_word;
		end
	end

	task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test;
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk_i);
		rd <= 1'b0;
		@(negedge core_clk_i);
		d = rdata;
	endtask

	task automatic reg_expect(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		reg_read(a, d);
		check_vec($sformatf("reg %h", a), exp, d);
	endtask

	// Period taken between the second and third rise, after the divider settles
	task automatic measure(input string what, input logic sel, input int exp);
		int t;
		int n;
		int s;
		t = 0;
		n = 0;
		s = 0;
		probe_sel = sel;
		while (n < 3 && t < 3000) begin
			@(posedge core_clk_i);
			t++;
			if (probe === 1'b1 && probe_q === 1'b0) begin
				n++;
				if (n == 2)
					s = t;
			end
		end
		if (n < 3) begin
			errors++;
			stop_test();
		end else begin
			check_vec(what, 32'(exp), 32'(t - s));
		end
	endtask

	// Word repeats every 16 bits, so any 16 samples hold its ones; skip the reload
	task automatic check_serial_out;
		int t;
		int n;
		int ones;
		t = 0;
		n = 0;
		ones = 0;
		probe_sel = 1'b1;
		reg_write(`SA_TX_WORD_ADDR, 32'h0000_0E01);
		while (n < 48 && t < 4000) begin
			@(posedge core_clk_i);
			t++;
			if (probe === 1'b1 && probe_q === 1'b0) begin
				n++;
				if (n > 32 && sout !== {4{sout[0]}})
					ones += 100;
				else if (n > 32 && sout[0] === 1'b1)
					ones++;
			end
		end
		if (n < 48) begin
			errors++;
			stop_test();
		end else begin
			check_vec("serial out ones", 32'h4, 32'(ones));
		end
	endtask

	task automatic check_reset;
		check_vec("multiplier", 32'h4, 32'(mult));
		check_vec("divisor", 32'h0D58, 32'(divisor));
		check_vec("format", 32'(FMT_DELAYED), 32'(fmt));
		reg_expect(`SA_IN_CFG_ADDR, 32'h0000_1001);
		reg_expect(`SA_OUT_CFG_ADDR, 32'h0000_1001);
		reg_expect(`SA_PLL_SEL_ADDR, 32'h0);
		reg_expect(`SA_PLL_RATIO_ADDR, 32'h000D_5804);
		reg_expect(5'h1C, 32'h0);
	endtask

	task automatic check_clocks;
		reg_write(`SA_IN_CFG_ADDR, 32'h0000_1101);
		measure("input bclk system", 1'b0, 8);
		reg_write(`SA_PLL_SEL_ADDR, 32'h2);
		measure("input bclk pll", 1'b0, 16);
		reg_write(`SA_OUT_CFG_ADDR, 32'h0000_9102);
		measure("output bclk", 1'b1, 64);
		check_serial_out();
		check_vec("drivers", 32'hF, {28'h0, ib_oe, if_oe, ob_oe, mck_oe});
		reg_write(`SA_OUT_CFG_ADDR, 32'h0000_1102);
		repeat (3) @(posedge core_clk_i);
		check_vec("pin released", 32'h0, 32'(mck_oe));
		measure("output bclk from pin", 1'b1, 32);
	endtask

	task automatic check_receiver;
		logic [31:0] st;
		lock <= 1'b1;
		reg_write(`SA_PLL_RATIO_ADDR, 32'h0006_2406);
		reg_write(`SA_PLL_SEL_ADDR, 32'h9);
		repeat (5) @(posedge core_clk_i);
		check_vec("ratio", 32'h0006_2406, {8'h0, divisor, mult});
		check_vec("pll ref", 32'h1, 32'(pll_ref));
		check_vec("pin driven", 32'h1, 32'(mck_oe));
		reg_read(`SA_STATUS_ADDR, st);
		check_vec("lock", 32'h1, 32'(st[3]));
		reg_write(`SA_IN_CFG_ADDR, 32'h0000_1102);
		measure("single rate", 1'b0, 64);
		reg_write(`SA_PLL_SEL_ADDR, 32'hD);
		measure("double rate", 1'b0, 32);
	endtask

	// Stray bits first; only the sync may bring the word into line
	task automatic run_frameless(input logic pol, input logic [15:0] word);
		reg_write(`SA_IN_CFG_ADDR, 32'h0000_6000 | (32'(pol) << 9));
		inv <= pol;
		repeat (2) @(posedge core_clk_i);
		check_vec("format", 32'(FMT_FRAMELESS), 32'(fmt));
		n_words = 0;
		u_src.send(16'h0055, 7, 1'b0);
		u_src.send(word, 16, 1'b1);
		repeat (10) @(posedge core_clk_i);
		check_vec("word count", 32'h1, 32'(n_words));
		check_vec("word", 32'(word), 32'(last_word));
	endtask

	initial begin
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		check_reset();
		check_clocks();
		check_receiver();
		run_frameless(1'b1, 16'hA5C3);
		run_frameless(1'b0, 16'h3C96);
		stop_test();
	end
endmodule
